// ### include/acr_pkg.sv
// Package: register map, field layout and types for the converter config block
package acr_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0]  IDX_PAIR     = 8'hba;
	localparam logic [7:0]  IDX_CLKGAIN  = 8'hbc;
	localparam logic [7:0]  IDX_CTRL     = 8'hc0;
	localparam logic [7:0]  IDX_RESULT   = 8'hc1;
	localparam int          ADDR_W       = 12;
	// Field positions
	localparam int          PER_LSB      = 5;
	localparam int          GAIN_LSB     = 0;
	localparam int          CTRL_START   = 0;
	localparam int          CTRL_CH_LSB  = 4;
	localparam int          CTRL_BUSY    = 8;
	localparam int          RES_DIFF     = 16;
	// Reset values
	localparam logic [7:0]  CLKGAIN_RST  = 8'h60;
	localparam logic [2:0]  PER_RST      = 3'h3;
	localparam logic [2:0]  GAIN_RST     = 3'h0;
	localparam logic [3:0]  PAIR_RST     = 4'h0;
	// Timing
	localparam logic [4:0]  CONV_TICKS   = 5'h10;
	localparam int          RES_W        = 12;
	// Gain codes, in units of one half
	localparam logic [5:0]  GAIN_H1      = 6'h02;
	localparam logic [5:0]  GAIN_H2      = 6'h04;
	localparam logic [5:0]  GAIN_H4      = 6'h08;
	localparam logic [5:0]  GAIN_H8      = 6'h10;
	localparam logic [5:0]  GAIN_H16     = 6'h20;
	localparam logic [5:0]  GAIN_HHALF   = 6'h01;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	typedef struct packed {
		logic [2:0] period;
		logic [2:0] gain;
		logic [3:0] pair_diff;
	} acr_cfg_t;

	typedef enum logic {
		ACR_IDLE,
		ACR_CONV
	} acr_state_t;
endpackage : acr_pkg

// ### hw/acr_top.sv
// Converter clock, gain, input pairing registers and conversion sequencer
`timescale 1ns/1ps
module acr_top #(
	parameter int RES_W = acr_pkg::RES_W
) (
	input  wire logic                 clock_i,
	input  wire logic                 rst_i,
	input  wire logic [11:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output      logic                 s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output      logic                 s_axi_wready,
	output      logic [1:0]           s_axi_bresp,
	output      logic                 s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [11:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output      logic                 s_axi_arready,
	output      logic [31:0]          s_axi_rdata,
	output      logic [1:0]           s_axi_rresp,
	output      logic                 s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 debug_halt_i,
	input  wire logic [RES_W-1:0]     raw_code_i,
	output      acr_pkg::acr_cfg_t    cfg_o,
	output      logic [5:0]           amp_gain_halves_o,
	output      logic [2:0]           chan_sel_o,
	output      logic                 sar_tick_o,
	output      logic                 busy_o,
	output      logic                 done_o,
	output      logic [RES_W-1:0]     result_o
);
	// Gain decode, used only by the amplifier output; its checks use literal codes
	function automatic logic [5:0] gain_halves(input logic [2:0] g);
		case (g)
			3'h0:    gain_halves = acr_pkg::GAIN_H1;
			3'h1:    gain_halves = acr_pkg::GAIN_H2;
			3'h2:    gain_halves = acr_pkg::GAIN_H4;
			3'h3:    gain_halves = acr_pkg::GAIN_H8;
			3'h4,
			3'h5:    gain_halves = acr_pkg::GAIN_H16;
			default: gain_halves = acr_pkg::GAIN_HHALF;
		endcase
	endfunction : gain_halves

	// Offset-binary raw code to output format
	function automatic logic [RES_W-1:0] fmt(input logic [RES_W-1:0] raw,
	                                         input logic             diff);
		fmt = diff ? {~raw[RES_W-1], raw[RES_W-2:0]} : raw;
	endfunction : fmt

	acr_pkg::acr_cfg_t   cfg_q;
	acr_pkg::acr_state_t state_q;
	localparam int       ADDR_W_L = acr_pkg::ADDR_W;
	logic [ADDR_W_L-1:0] aw_addr_q;
	logic                aw_full_q;
	logic [31:0]         w_data_q;
	logic [3:0]          w_strb_q;
	logic                w_full_q;
	logic                bvalid_q;
	logic [1:0]          bresp_q;
	logic                rvalid_q;
	logic [1:0]          rresp_q;
	logic [31:0]         rdata_q;
	logic [2:0]          chan_q;
	logic [2:0]          conv_per_q;
	logic [2:0]          div_q;
	logic [4:0]          tick_cnt_q;
	logic                done_q;
	logic                res_diff_q;
	logic [RES_W-1:0]    result_q;
	logic                do_write;
	logic                start;
	logic                tick;
	logic                chan_diff;
	logic [7:0]          wr_idx;
	logic [7:0]          rd_idx;

	assign wr_idx   = aw_addr_q[9:2];
	assign rd_idx   = s_axi_araddr[9:2];
	assign do_write = aw_full_q && w_full_q && !bvalid_q;
	assign start    = do_write && w_strb_q[0] && wr_idx == acr_pkg::IDX_CTRL
	                  && w_data_q[acr_pkg::CTRL_START];

	// Write side: address and data latched independently, either order
	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready  = !w_full_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
			bvalid_q  <= 1'b0;
			bresp_q   <= acr_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_full_q) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_q) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= (aw_addr_q[11:10] == 2'h0
				              && (wr_idx == acr_pkg::IDX_PAIR
				              || wr_idx == acr_pkg::IDX_CLKGAIN
				              || wr_idx == acr_pkg::IDX_CTRL
				              || wr_idx == acr_pkg::IDX_RESULT))
				             ? acr_pkg::RESP_OKAY : acr_pkg::RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Configuration registers; result register ignores writes
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			cfg_q.period    <= acr_pkg::PER_RST;
			cfg_q.gain      <= acr_pkg::GAIN_RST;
			cfg_q.pair_diff <= acr_pkg::PAIR_RST;
			chan_q          <= 3'h0;
		end else if (do_write && w_strb_q[0]) begin
			case (wr_idx)
				acr_pkg::IDX_PAIR: begin
					cfg_q.pair_diff <= w_data_q[3:0];
				end
				acr_pkg::IDX_CLKGAIN: begin
					cfg_q.period <= w_data_q[acr_pkg::PER_LSB +: 3];
					cfg_q.gain   <= w_data_q[acr_pkg::GAIN_LSB +: 3];
				end
				acr_pkg::IDX_CTRL: begin
					// Channel is frozen during a conversion
					if (state_q == acr_pkg::ACR_IDLE) begin
						chan_q <= w_data_q[acr_pkg::CTRL_CH_LSB +: 3];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Read side: one outstanding read, answer one cycle after address
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0;
			rresp_q  <= acr_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q  <= 32'h0;
			rresp_q  <= acr_pkg::RESP_OKAY;
			if (s_axi_araddr[11:10] != 2'h0) begin
				rresp_q <= acr_pkg::RESP_SLVERR;
			end else begin
				case (rd_idx)
					acr_pkg::IDX_PAIR: begin
						rdata_q[3:0] <= cfg_q.pair_diff;
					end
					acr_pkg::IDX_CLKGAIN: begin
						rdata_q[7:0] <= {cfg_q.period, 2'h0, cfg_q.gain};
					end
					acr_pkg::IDX_CTRL: begin
						rdata_q[acr_pkg::CTRL_CH_LSB +: 3] <= chan_q;
						rdata_q[acr_pkg::CTRL_BUSY] <=
							state_q == acr_pkg::ACR_CONV;
					end
					acr_pkg::IDX_RESULT: begin
						rdata_q[RES_W-1:0]        <= result_q;
						rdata_q[acr_pkg::RES_DIFF] <= res_diff_q;
					end
					default: begin
						rresp_q <= acr_pkg::RESP_SLVERR;
					end
				endcase
			end
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Converter clock divider; period latched at start so edits mid-run
	// cannot stretch a conversion. Debug halt is deliberately not an input.
	assign tick      = state_q == acr_pkg::ACR_CONV && div_q == conv_per_q;
	assign chan_diff = cfg_q.pair_diff[chan_q[2:1]];
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_q    <= acr_pkg::ACR_IDLE;
			conv_per_q <= acr_pkg::PER_RST;
			div_q      <= 3'h0;
			tick_cnt_q <= 5'h0;
			done_q     <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (state_q)
				acr_pkg::ACR_IDLE: begin
					if (start) begin
						state_q    <= acr_pkg::ACR_CONV;
						conv_per_q <= cfg_q.period;
						div_q      <= 3'h0;
						tick_cnt_q <= 5'h0;
					end
				end
				acr_pkg::ACR_CONV: begin
					// No stall term: runs through halt and single-step
					div_q <= tick ? 3'h0 : div_q + 3'h1;
					if (tick) begin
						tick_cnt_q <= tick_cnt_q + 5'h1;
						if (tick_cnt_q == acr_pkg::CONV_TICKS - 5'h1) begin
							state_q <= acr_pkg::ACR_IDLE;
							done_q  <= 1'b1;
						end
					end
				end
				default: begin
					state_q <= acr_pkg::ACR_IDLE;
				end
			endcase
		end
	end

	// Result capture at the last converter clock
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			result_q   <= '0;
			res_diff_q <= 1'b0;
		end else if (tick && tick_cnt_q == acr_pkg::CONV_TICKS - 5'h1) begin
			result_q   <= fmt(raw_code_i, chan_diff);
			res_diff_q <= chan_diff;
		end
	end

	assign cfg_o             = cfg_q;
	assign amp_gain_halves_o = gain_halves(cfg_q.gain);
	assign chan_sel_o        = chan_q;
	assign sar_tick_o        = tick;
	assign busy_o            = state_q == acr_pkg::ACR_CONV;
	assign done_o            = done_q;
	assign result_o          = result_q;

	// Checks
	logic [7:0] cyc_q;
	always_ff @(posedge clock_i) begin
		// A start while busy is ignored, so it must not restart the count
		if (rst_i || (start && state_q == acr_pkg::ACR_IDLE)) begin
			cyc_q <= 8'h0;
		end else if (state_q == acr_pkg::ACR_CONV) begin
			cyc_q <= cyc_q + 8'h1;
		end
	end

	AST_CFG_RESET: assert property (@(posedge clock_i)
		$past(rst_i) |-> cfg_q.period == 3'h3 && cfg_q.gain == 3'h0
		&& cfg_q.pair_diff == 4'h0)
		else $error("config not at reset value");
	AST_CONV_LEN: assert property (@(posedge clock_i) disable iff (rst_i)
		done_q |-> cyc_q == 8'(16 * ({5'h0, conv_per_q} + 8'h1)))
		else $error("conversion not 16 converter clocks");
	AST_HALT_RUNS: assert property (@(posedge clock_i) disable iff (rst_i)
		(busy_o && debug_halt_i) |-> ##[0:8] (tick || !busy_o))
		else $error("converter stalled during halt");
	AST_DIFF_FMT: assert property (@(posedge clock_i) disable iff (rst_i)
		(done_q && res_diff_q) |-> result_q[RES_W-1] != $past(raw_code_i[RES_W-1])
		&& result_q[RES_W-2:0] == $past(raw_code_i[RES_W-2:0]))
		else $error("differential result not two's complement");
	AST_SE_FMT: assert property (@(posedge clock_i) disable iff (rst_i)
		(done_q && !res_diff_q) |-> result_q == $past(raw_code_i))
		else $error("single-ended result altered");
	AST_GAIN_HI: assert property (@(posedge clock_i) disable iff (rst_i)
		cfg_q.gain[2:1] == 2'h2 |-> amp_gain_halves_o == 6'h20)
		else $error("gain 16 decode wrong");
	AST_GAIN_HALF: assert property (@(posedge clock_i) disable iff (rst_i)
		cfg_q.gain[2:1] == 2'h3 |-> amp_gain_halves_o == 6'h01)
		else $error("gain half decode wrong");
	AST_PAIR_RD: assert property (@(posedge clock_i) disable iff (rst_i)
		(s_axi_arvalid && s_axi_arready && rd_idx == acr_pkg::IDX_PAIR
		&& s_axi_araddr[11:10] == 2'h0)
		|=> rdata_q[31:4] == 28'h0
		&& rdata_q[3:0] == $past(cfg_q.pair_diff))
		else $error("pairing readback wrong");
	AST_PER_WR: assert property (@(posedge clock_i) disable iff (rst_i)
		(do_write && w_strb_q[0] && wr_idx == acr_pkg::IDX_CLKGAIN)
		|=> cfg_q.period == $past(w_data_q[7:5]))
		else $error("period field not written");
	AST_B_HOLD: assert property (@(posedge clock_i) disable iff (rst_i)
		(bvalid_q && !s_axi_bready) |=> bvalid_q && $stable(bresp_q))
		else $error("write response dropped");

	COV_DIFF_CONV: cover property (@(posedge clock_i) done_q && res_diff_q);
	COV_SE_CONV: cover property (@(posedge clock_i) done_q && !res_diff_q);
	COV_HALT_CONV: cover property (@(posedge clock_i) busy_o && debug_halt_i
		##1 done_q);
endmodule : acr_top

// ### sim/acr_top_tb.sv
// Self-checking bench for the converter config registers and sequencer
`timescale 1ns/1ps
module acr_top_tb;
	logic              clock_i;
	logic              rst_i;
	logic [11:0]       awaddr;
	logic              awvalid;
	logic              awready;
	logic [31:0]       wdata;
	logic [3:0]        wstrb;
	logic              wvalid;
	logic              wready;
	logic [1:0]        bresp;
	logic              bvalid;
	logic              bready;
	logic [11:0]       araddr;
	logic              arvalid;
	logic              arready;
	logic [31:0]       rdata;
	logic [1:0]        rresp;
	logic              rvalid;
	logic              rready;
	logic              debug_halt_i;
	logic [11:0]       raw_code_i;
	acr_pkg::acr_cfg_t cfg_o;
	logic [5:0]        gain_h;
	logic [2:0]        chan_sel_o;
	logic              busy_o;
	logic              tick_o;
	logic              done_o;
	logic [11:0]       result_o;
	int                n_mismatch;
	int                checks;
	logic [1:0]        r;
	logic [31:0]       d;
	// Expected gain in halves for each gain code, row index is the code
	logic [5:0]        gh [8] = '{6'h02, 6'h04, 6'h08, 6'h10,
		6'h20, 6'h20, 6'h01, 6'h01};

	acr_top dut (.clock_i(clock_i), .rst_i(rst_i),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.debug_halt_i(debug_halt_i), .raw_code_i(raw_code_i),
		.cfg_o(cfg_o), .amp_gain_halves_o(gain_h),
		.chan_sel_o(chan_sel_o), .sar_tick_o(tick_o), .busy_o(busy_o),
		.done_o(done_o), .result_o(result_o));

	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end

	task automatic chk(input string nm, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic results;
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	// Address and data offered together, each released when taken
	task automatic wr(input logic [11:0] a, input logic [31:0] v,
		input logic [3:0] s, output logic [1:0] rs);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge clock_i);
		awaddr <= a;
		wdata <= v;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge clock_i);
			if (awvalid && awready) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clock_i); while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] v,
		output logic [1:0] rs);
		@(posedge clock_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clock_i); while (!(arready === 1'b1));
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge clock_i);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : rd

	// One conversion while the core is held halted
	task automatic conv(input logic [2:0] p, input logic [2:0] ch,
		input logic [3:0] pr, input logic [11:0] raw);
		int n;
		int nt;
		logic df;
		df = pr[ch >> 1];
		wr(12'h2f0, {24'h0, p, 5'h00}, 4'hf, r);
		wr(12'h2e8, {28'h0, pr}, 4'hf, r);
		debug_halt_i <= 1'b1;
		raw_code_i <= raw;
		wr(12'h300, {25'h0, ch, 4'h1}, 4'hf, r);
		chk("busy", busy_o, 1'b1);
		n = 1;
		// First converter clock may already stand on return, at period 0
		nt = (tick_o === 1'b1) ? 1 : 0;
		do begin
			@(posedge clock_i);
			n++;
			if (tick_o === 1'b1)
				nt++;
		end while (done_o !== 1'b1 && n < 400);
		chk("conv_len", n - 1, 16 * (p + 1));
		chk("ticks", nt, 16);
		chk("chan", chan_sel_o, ch);
		chk("result", result_o, df ? raw ^ 12'h800 : raw);
		rd(12'h304, d, r);
		chk("res_diff", d[16], df);
		debug_halt_i <= 1'b0;
	endtask : conv

	initial begin
		#20000;
		n_mismatch++;
		results();
	end

	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready, debug_halt_i, raw_code_i} = '0;
		n_mismatch = 0;
		checks = 0;
		rst_i = 1'b1;
		repeat (16) @(posedge clock_i);
		rst_i <= 1'b0;
		rd(12'h2f0, d, r);
		chk("clkgain_rst", d, 32'h60);
		chk("period_rst", cfg_o.period, 3'h3);
		rd(12'h2e8, d, r);
		chk("pair_rst", d, 32'h0);
		// Every gain code, bits 4:3 written high must read zero
		for (int i = 0; i < 8; i++) begin
			wr(12'h2f0, 32'h18 | (i << 5) | i, 4'h1, r);
			rd(12'h2f0, d, r);
			chk("clkgain_rd", d, (i << 5) | i);
			chk("gain_halves", gain_h, gh[i]);
			chk("cfg_gain", cfg_o.gain, i[2:0]);
		end
		// Write lanes without the low byte leave the register alone
		wr(12'h2f0, 32'h00, 4'he, r);
		rd(12'h2f0, d, r);
		chk("strb_ignored", d, 32'he7);
		wr(12'h2e8, 32'hff, 4'hf, r);
		rd(12'h2e8, d, r);
		chk("pair_unused", d, 32'h0f);
		chk("cfg_pair", cfg_o.pair_diff, 4'hf);
		// Unmapped place answers with an error and changes nothing
		wr(12'hc00, 32'h5a, 4'hf, r);
		chk("unmapped_wr", r, acr_pkg::RESP_SLVERR);
		rd(12'hc00, d, r);
		chk("unmapped_rd", r, acr_pkg::RESP_SLVERR);
		// Fastest, slowest and a middle period; the rate limit is software's
		conv(3'h0, 3'h1, 4'h1, 12'h123);
		conv(3'h7, 3'h5, 4'hb, 12'h9ab);
		conv(3'h2, 3'h6, 4'h8, 12'h7f0);
		// Second start while busy ignored, then reset in mid-conversion
		wr(12'h2f0, 32'he5, 4'h1, r);
		wr(12'h300, 32'h01, 4'h1, r);
		wr(12'h300, 32'h31, 4'h1, r);
		chk("busy_hold", busy_o, 1'b1);
		chk("busy_chan", chan_sel_o, 3'h0);
		rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		chk("rst_busy", busy_o, 1'b0);
		chk("rst_done", done_o, 1'b0);
		chk("rst_period", cfg_o.period, acr_pkg::PER_RST);
		chk("rst_pair", cfg_o.pair_diff, acr_pkg::PAIR_RST);
		chk("rst_result", result_o, 32'h0);
		rd(12'h2f0, d, r);
		chk("rst_clkgain", d, acr_pkg::CLKGAIN_RST);
		rd(12'h2e8, d, r);
		chk("rst_pair_rd", d, 32'h0);
		results();
	end
endmodule : acr_top_tb
